//--- lsp_defines.svh
// register indices, field positions, reset values and timing counts
`ifndef LSP_DEFINES_SVH
`define LSP_DEFINES_SVH

// register indices; byte address is four times the index
`define LSP_IDX_SEL       10'h10d
`define LSP_IDX_PRESCALE  10'h10e
`define LSP_IDX_CONTROL   10'h10f
`define LSP_IDX_PIX_FIRST 10'h110
`define LSP_IDX_PIX_LAST  10'h11f
`define LSP_IDX_IRQ_STAT  10'h120
`define LSP_IDX_IRQ_MASK  10'h121
`define LSP_IDX_PIN_IN    10'h122
`define LSP_IDX_SEQ       10'h123

// reset values
`define LSP_SEL_RESET     8'hff
`define LSP_PRESCALE_RST  4'h0
`define LSP_CON_RESET     8'h00
`define LSP_IRQ_RESET     2'h0

// control register: bit 5 unimplemented, reads zero
`define LSP_CON_WMASK     8'hdf
`define LSP_CON_EN_BIT    7

// select bit per low pin group
`define LSP_SEL_G0_BIT    0
`define LSP_SEL_G5_BIT    1
`define LSP_SEL_G9_BIT    2
`define LSP_SEL_G12_BIT   3

// first pin of each low group
`define LSP_G5_FIRST      5
`define LSP_G9_FIRST      9
`define LSP_G12_FIRST     12

// status bit positions
`define LSP_IRQ_FRAME_BIT 0
`define LSP_IRQ_ORDER_BIT 1

// last core_clk count of a prescale step of the frame clock; a step lasts this plus one cycles
`define LSP_FRAME_BASE_CYCLES 4'hf

`endif

//--- lsp_frame_div.sv
// frame clock divider: one tick per prescale-scaled frame period
`timescale 1ns/1ps
`include "lsp_defines.svh"

module lsp_frame_div (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [3:0] prescale,
  output logic            tick
);

  logic [3:0] base_cnt;
  logic [3:0] step_cnt;
  logic       base_wrap;

  assign base_wrap = (base_cnt == `LSP_FRAME_BASE_CYCLES);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      base_cnt <= 4'h0;
    end else if (!run || base_wrap) begin
      base_cnt <= 4'h0;
    end else begin
      base_cnt <= base_cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step_cnt <= 4'h0;
      tick     <= 1'b0;
    end else if (!run) begin
      step_cnt <= 4'h0;
      tick     <= 1'b0;
    end else if (base_wrap && step_cnt >= prescale) begin
      step_cnt <= 4'h0;
      tick     <= 1'b1;
    end else begin
      if (base_wrap) begin
        step_cnt <= step_cnt + 4'h1;
      end
      tick <= 1'b0;
    end
  end

endmodule

//--- lsp_pkg.sv
// types shared by the segment pin select block
package lsp_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lsp_apb_req_t;

  typedef struct packed {
    logic       display_module_on;
    logic       sleep_run_bit;
    logic       unused_zero;
    logic       charge_pump_select;
    logic [1:0] timing_source_field;
    logic [1:0] mux_bias_field;
  } lsp_ctl_t;

  typedef enum logic [5:0] {
    SQ_RESET    = 6'b00_0001,
    SQ_PRESCALE = 6'b00_0010,
    SQ_SELECT   = 6'b00_0100,
    SQ_CONTROL  = 6'b00_1000,
    SQ_PIXELS   = 6'b01_0000,
    SQ_READY    = 6'b10_0000
  } lsp_seq_t;

endpackage

//--- lsp_seg_pin_cfg.sv
// segment pin function select, bias rail control and bring-up registers
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "lsp_defines.svh"

module lsp_seg_pin_cfg (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire lsp_pkg::lsp_apb_req_t apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic [15:0]           seg_pin_in,
  output logic [15:0]                seg_lcd_func,
  output logic [15:0]                seg_digital_in,
  output logic                       pump_run,
  output logic                       vlcd3_tie_vdd,
  output logic                       irq
);
  import lsp_pkg::*;

  logic [7:0]  segment_pin_select;
  logic [3:0]  frame_prescale_field;
  lsp_ctl_t    display_control_reg;
  logic [7:0]  pixel_data [16];
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  lsp_seq_t    seq_state;
  logic [15:0] pix_seen;
  logic [15:0] pin_meta;
  logic [15:0] pin_sync;
  logic [1:0]  rd_stat_snap;
  logic        frame_tick;

  logic        access;
  logic        wr_fire;
  logic        rd_fire;
  logic [9:0]  idx;
  logic        wr_sel;
  logic        wr_ps;
  logic        wr_con;
  logic        wr_pix;
  logic        wr_mask;
  logic        rd_stat;
  logic        order_err;
  logic [1:0]  events;
  logic [31:0] next_rdata;
  logic        next_err;
  logic        next_pump;

  // pin group index (0..3) of a low segment pin
  function automatic logic [1:0] group_of(input int pin);
    if (pin >= `LSP_G12_FIRST) begin
      return 2'd3;
    end else if (pin >= `LSP_G9_FIRST) begin
      return 2'd2;
    end else if (pin >= `LSP_G5_FIRST) begin
      return 2'd1;
    end else begin
      return 2'd0;
    end
  endfunction

  // word index falls in the pixel block
  function automatic logic is_pix(input logic [9:0] i);
    return (i >= `LSP_IDX_PIX_FIRST) && (i <= `LSP_IDX_PIX_LAST);
  endfunction

  // apb handshake: one wait state, then pready
  assign access  = apb_req.psel & apb_req.penable;
  assign wr_fire = access & pready & apb_req.pwrite;
  assign rd_fire = access & pready & !apb_req.pwrite;
  assign idx     = apb_req.paddr[11:2];
  assign wr_sel  = wr_fire && idx == `LSP_IDX_SEL;
  assign wr_ps   = wr_fire && idx == `LSP_IDX_PRESCALE;
  assign wr_con  = wr_fire && idx == `LSP_IDX_CONTROL;
  assign wr_pix  = wr_fire && is_pix(idx);
  assign wr_mask = wr_fire && idx == `LSP_IDX_IRQ_MASK;
  assign rd_stat = rd_fire && idx == `LSP_IDX_IRQ_STAT;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= access & !pready;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (is_pix(idx)) begin
      next_rdata[7:0] = pixel_data[idx[3:0]];
    end else begin
      case (idx)
        `LSP_IDX_SEL:      next_rdata[7:0]  = segment_pin_select;
        `LSP_IDX_PRESCALE: next_rdata[3:0]  = frame_prescale_field;
        `LSP_IDX_CONTROL:  next_rdata[7:0]  = display_control_reg;
        `LSP_IDX_IRQ_STAT: next_rdata[1:0]  = irq_status;
        `LSP_IDX_IRQ_MASK: next_rdata[1:0]  = irq_mask;
        `LSP_IDX_PIN_IN:   next_rdata[15:0] = seg_digital_in;
        `LSP_IDX_SEQ:      next_rdata[5:0]  = seq_state;
        default:           next_err         = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata       <= 32'h0000_0000;
      pslverr      <= 1'b0;
      rd_stat_snap <= 2'h0;
    end else if (access && !pready) begin
      prdata       <= apb_req.pwrite ? 32'h0000_0000 : next_rdata;
      pslverr      <= next_err;
      rd_stat_snap <= irq_status;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      segment_pin_select <= `LSP_SEL_RESET;
    end else if (wr_sel) begin
      segment_pin_select <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      frame_prescale_field <= `LSP_PRESCALE_RST;
    end else if (wr_ps) begin
      frame_prescale_field <= apb_req.pwdata[3:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      display_control_reg <= lsp_ctl_t'(`LSP_CON_RESET);
    end else if (wr_con) begin
      display_control_reg <= lsp_ctl_t'(apb_req.pwdata[7:0] & `LSP_CON_WMASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_pix) begin
      pixel_data[idx[3:0]] <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_mask <= `LSP_IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask <= apb_req.pwdata[1:0];
    end
  end

  // bring-up order tracking
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seq_state <= SQ_RESET;
    end else if (wr_ps) begin
      seq_state <= SQ_PRESCALE;
    end else begin
      case (seq_state)
        SQ_RESET: begin
          seq_state <= SQ_RESET;
        end
        SQ_PRESCALE: begin
          if (wr_sel) begin
            seq_state <= SQ_SELECT;
          end
        end
        SQ_SELECT: begin
          if (wr_con && !apb_req.pwdata[`LSP_CON_EN_BIT]) begin
            seq_state <= SQ_CONTROL;
          end
        end
        SQ_CONTROL: begin
          if (wr_pix && (pix_seen | (16'h0001 << idx[3:0])) == 16'hffff) begin
            seq_state <= SQ_PIXELS;
          end
        end
        SQ_PIXELS: begin
          if (rd_stat) begin
            seq_state <= SQ_READY;
          end
        end
        SQ_READY: begin
          seq_state <= SQ_READY;
        end
        default: begin
          seq_state <= SQ_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pix_seen <= 16'h0000;
    end else if (seq_state != SQ_CONTROL) begin
      pix_seen <= 16'h0000;
    end else if (wr_pix) begin
      pix_seen <= pix_seen | (16'h0001 << idx[3:0]);
    end
  end

  // enable written before the sequence completed
  assign order_err = wr_con && apb_req.pwdata[`LSP_CON_EN_BIT]
                     && !display_control_reg.display_module_on
                     && seq_state != SQ_READY;

  lsp_frame_div u_frame_div (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (display_control_reg.display_module_on),
    .prescale (frame_prescale_field),
    .tick     (frame_tick)
  );

  // sticky status, cleared by read, set wins
  assign events = {order_err, frame_tick};

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_status <= `LSP_IRQ_RESET;
    end else if (rd_stat) begin
      irq_status <= (irq_status & ~rd_stat_snap) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // pin routing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seg_lcd_func <= 16'hffff;
    end else begin
      for (int p = 0; p < 16; p++) begin
        seg_lcd_func[p] <= segment_pin_select[group_of(p)];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end else begin
      pin_meta <= seg_pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seg_digital_in <= 16'h0000;
    end else begin
      for (int p = 0; p < 16; p++) begin
        seg_digital_in[p] <= segment_pin_select[group_of(p)] ? 1'b0 : pin_sync[p];
      end
    end
  end

  // charge pump runs only when selected and module on; else ladder bias
  assign next_pump = display_control_reg.display_module_on
                     && display_control_reg.charge_pump_select;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pump_run      <= 1'b0;
      vlcd3_tie_vdd <= 1'b1;
    end else begin
      pump_run      <= next_pump;
      vlcd3_tie_vdd <= !next_pump;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  chk_group12_route: assert property (
    wr_sel && !wr_ps |-> ##2 (seg_lcd_func[15:12] == {4{$past(apb_req.pwdata[3], 2)}}))
    else $error("segment 12 group routing wrong");

  chk_group9_route: assert property (
    wr_sel |-> ##2 (seg_lcd_func[11:9] == {3{$past(apb_req.pwdata[2], 2)}}))
    else $error("segment 9 group routing wrong");

  chk_group5_route: assert property (
    ##1 (seg_lcd_func[8:5] == {4{$past(segment_pin_select[1])}}))
    else $error("segment 5 group routing wrong");

  chk_group0_route: assert property (
    wr_sel && !apb_req.pwdata[0] |=> ##1 (seg_lcd_func[4:0] == 5'h00) [*2])
    else $error("segment 0 group routing wrong");

  chk_digital_input_only: assert property (
    ##2 ((seg_lcd_func & seg_digital_in) == 16'h0000))
    else $error("lcd pin shows digital input");

  chk_rail_tie: assert property (
    vlcd3_tie_vdd == !pump_run)
    else $error("bias rail tie disagrees with pump state");

  chk_pump_start: assert property (
    $rose(display_control_reg.display_module_on) && display_control_reg.charge_pump_select
    |=> pump_run && !vlcd3_tie_vdd)
    else $error("pump did not start with module enable");

  cov_enable_in_order: cover property (
    wr_con && apb_req.pwdata[`LSP_CON_EN_BIT] && seq_state == SQ_READY);

  cov_order_error: cover property (order_err);

  cov_frame_irq: cover property (frame_tick && irq_mask[`LSP_IRQ_FRAME_BIT] ##2 irq);

endmodule

//--- lsp_seg_pin_cfg_tb_top.sv
// self-checking bench for the segment pin select block
`timescale 1ns/1ps
`include "lsp_defines.svh"
module lsp_seg_pin_cfg_tb_top;
  import lsp_pkg::*;
  typedef struct packed {
    logic [7:0]  sel;
    logic [15:0] pins;
    logic [15:0] lcd;
  } lsp_row_t;
  logic         core_clk = 1'b0;
  logic         reset = 1'b1;
  lsp_apb_req_t req = '0;
  logic [15:0]  seg_pin_in = 16'h0000;
  logic         pready, pslverr, pump_run, vlcd3_tie_vdd, irq;
  logic [31:0]  prdata, rd;
  logic [15:0]  seg_lcd_func, seg_digital_in;
  logic         err;
  int           mismatches = 0;
  int           checked = 0;
  int           cycles = 0;
  lsp_row_t     rows [6] = '{
    '{8'h00, 16'ha5c3, 16'h0000},
    '{8'h01, 16'hffff, 16'h001f},
    '{8'h02, 16'hffff, 16'h01e0},
    '{8'h04, 16'hffff, 16'h0e00},
    '{8'h08, 16'hffff, 16'hf000},
    '{8'hf5, 16'h5a5a, 16'h0e1f}};

  lsp_seg_pin_cfg lsp_seg_pin_cfg_i (
    .core_clk       (core_clk),
    .reset          (reset),
    .apb_req        (req),
    .pready         (pready),
    .prdata         (prdata),
    .pslverr        (pslverr),
    .seg_pin_in     (seg_pin_in),
    .seg_lcd_func   (seg_lcd_func),
    .seg_digital_in (seg_digital_in),
    .pump_run       (pump_run),
    .vlcd3_tie_vdd  (vlcd3_tie_vdd),
    .irq            (irq)
  );

  always #2.5 core_clk = ~core_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge core_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    chk("apb_wait", 32'h0000_0002, n);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("lcd_func_rst", 32'h0000_ffff, {16'h0000, seg_lcd_func});
    chk("tie_rst", 32'h0000_0001, {31'h0, vlcd3_tie_vdd});
    chk("irq_rst", 32'h0000_0000, {31'h0, irq});
    reset <= 1'b0;
    apb(1'b0, `LSP_IDX_SEL, 32'h0);
    chk("sel_rst", 32'h0000_00ff, rd);
    apb(1'b0, `LSP_IDX_CONTROL, 32'h0);
    chk("ctl_rst", 32'h0000_0000, rd);
    $display("test reset done");
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      seg_pin_in <= rows[i].pins;
      apb(1'b1, `LSP_IDX_SEL, {24'h0, rows[i].sel});
      repeat (4) @(posedge core_clk);
      chk("lcd_func", {16'h0, rows[i].lcd}, {16'h0, seg_lcd_func});
      chk("dig_in", {16'h0, rows[i].pins & ~rows[i].lcd}, {16'h0, seg_digital_in});
      apb(1'b0, `LSP_IDX_PIN_IN, 32'h0);
      chk("pin_reg", {16'h0, rows[i].pins & ~rows[i].lcd}, rd);
      apb(1'b0, `LSP_IDX_SEL, 32'h0);
      chk("sel_rd", {24'h0, rows[i].sel}, rd);
    end
    $display("test pin table done");
    // ordered bring-up with charge pump, frame interrupt
    apb(1'b1, `LSP_IDX_PRESCALE, 32'h0000_0001);
    apb(1'b1, `LSP_IDX_SEL, 32'h0000_000f);
    apb(1'b1, `LSP_IDX_CONTROL, 32'h0000_0053);
    for (int p = 0; p < 16; p++) begin
      apb(1'b1, `LSP_IDX_PIX_FIRST + 10'(p), {24'h0, 8'(p)});
    end
    apb(1'b0, `LSP_IDX_IRQ_STAT, 32'h0);
    apb(1'b0, `LSP_IDX_SEQ, 32'h0);
    chk("seq_ready", 32'h0000_0020, rd);
    apb(1'b0, `LSP_IDX_PRESCALE, 32'h0);
    chk("ps_rd", 32'h0000_0001, rd);
    apb(1'b0, `LSP_IDX_PIX_LAST, 32'h0);
    chk("pix_last", 32'h0000_000f, rd);
    apb(1'b1, `LSP_IDX_IRQ_MASK, 32'h0000_0001);
    apb(1'b0, `LSP_IDX_IRQ_MASK, 32'h0);
    chk("mask_rd", 32'h0000_0001, rd);
    apb(1'b1, `LSP_IDX_CONTROL, 32'h0000_00d3);
    repeat (2) @(posedge core_clk);
    chk("pump_on", 32'h0000_0001, {31'h0, pump_run});
    chk("tie_off", 32'h0000_0000, {31'h0, vlcd3_tie_vdd});
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(posedge core_clk);
    chk("irq_frame", 32'h0000_0001, {31'h0, irq});
    apb(1'b0, `LSP_IDX_IRQ_STAT, 32'h0);
    chk("stat_frame", 32'h0000_0001, rd & 32'h0000_0003);
    apb(1'b1, `LSP_IDX_IRQ_MASK, 32'h0000_0000);
    apb(1'b0, `LSP_IDX_IRQ_STAT, 32'h0);
    repeat (40) @(posedge core_clk);
    chk("irq_masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, `LSP_IDX_CONTROL, 32'h0000_0080);
    repeat (2) @(posedge core_clk);
    chk("pump_ladder", 32'h0000_0000, {31'h0, pump_run});
    chk("tie_ladder", 32'h0000_0001, {31'h0, vlcd3_tie_vdd});
    $display("test bring-up done");
    // unmapped places refused
    apb(1'b0, 10'h000, 32'h0);
    chk("unmap_rd", 32'h0000_0000, rd);
    chk("unmap_err", 32'h0000_0001, {31'h0, err});
    apb(1'b1, 10'h3ff, 32'h1234_5678);
    chk("unmap_wr_err", 32'h0000_0001, {31'h0, err});
    $display("test unmapped done");
    // second reset, then enable out of order
    do_reset();
    apb(1'b1, `LSP_IDX_IRQ_MASK, 32'h0000_0002);
    apb(1'b1, `LSP_IDX_CONTROL, 32'h0000_00ff);
    repeat (3) @(posedge core_clk);
    chk("irq_order", 32'h0000_0001, {31'h0, irq});
    chk("pump_order", 32'h0000_0001, {31'h0, pump_run});
    apb(1'b0, `LSP_IDX_CONTROL, 32'h0);
    chk("ctl_rd", 32'h0000_00df, rd);
    apb(1'b0, `LSP_IDX_IRQ_STAT, 32'h0);
    chk("stat_order", 32'h0000_0002, rd & 32'h0000_0002);
    $display("test order error done");
    stop_test();
  end
endmodule
